/* core/ctd_pkg.sv */
// ctd_pkg: constants, types and the length/clock table of the ctd core.
// Assumes one system clock; the package holds no logic of its own.
package ctd_pkg;
  localparam int DATA_W = 32;
  localparam int INSN_W = 18;
  // Register byte offsets on the plain port
  localparam logic [7:0] OFS_INSN = 8'h00;
  localparam logic [7:0] OFS_OPER = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_PSW = 8'h0c;
  localparam logic [7:0] OFS_CLKSEL = 8'h10;
  localparam logic [7:0] OFS_PC = 8'h14;
  localparam logic [7:0] OFS_REGLO = 8'h18;
  localparam logic [7:0] OFS_REGHI = 8'h1c;
  localparam logic [7:0] OFS_MADDR = 8'h20;
  localparam logic [7:0] OFS_MDATA = 8'h24;
  localparam logic [7:0] OFS_SAVED = 8'h28;
  // Status word fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_LEN_LSB = 8;
  localparam int STAT_CYC_LSB = 16;
  // Operand windows
  localparam logic [15:0] SADDR_LO = 16'hfe20;
  localparam logic [15:0] SADDR_HI = 16'hff1f;
  localparam logic [15:0] VECT_LO = 16'h0040;
  localparam logic [15:0] VECT_HI = 16'h007f;
  localparam logic [7:0] SFR_PAGE = 8'hff;
  // Byte-register and pair codes
  localparam logic [2:0] R_X = 3'h0, R_A = 3'h1, R_C = 3'h2, R_B = 3'h3;
  localparam logic [2:0] R_E = 3'h4, R_D = 3'h5, R_L = 3'h6, R_H = 3'h7;
  localparam logic [1:0] RP_AX = 2'h0, RP_BC = 2'h1, RP_DE = 2'h2, RP_HL = 2'h3;
  // Program status word layout and reset values
  localparam int PSW_CY = 0;
  localparam int PSW_NONMASKABLE_IN_SERVICE_FLAG = 1;
  localparam int PSW_AC = 4;
  localparam int PSW_Z = 6;
  localparam int PSW_IE = 7;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [2:0] CLKSEL_MAX = 3'h4;
  // Instruction lengths and CPU clock counts
  localparam logic [3:0] LEN1 = 4'h1, LEN2 = 4'h2, LEN3 = 4'h3;
  localparam logic [3:0] CYC4 = 4'h4, CYC6 = 4'h6, CYC8 = 4'h8;
  localparam logic [3:0] BR_LEN = 4'h2, BR_CYC = 4'h6;
  localparam logic [3:0] TBL_LEN = 4'h1, TBL_CYC = 4'h6;
  localparam logic [3:0] FLG_LEN = 4'h2, FLG_CYC = 4'h4;

  typedef enum logic [3:0] {
    CL_MOV = 4'h0, CL_XCH = 4'h1, CL_XCHW = 4'h2, CL_MOVW = 4'h3, CL_BREL = 4'h4,
    CL_SUB = 4'h5, CL_ADD = 4'h6, CL_ADD_WITH_CARRY_OP = 4'h7, CL_BTBL = 4'hc, CL_FLAG = 4'hd
  } ctd_cls_e;
  typedef enum logic [3:0] {
    LC_REG, LC_ACC, LC_IMM, LC_SAD, LC_SFR, LC_ABS, LC_DE, LC_HL, LC_HLB, LC_PSW, LC_RP
  } ctd_loc_e;
  typedef enum logic [2:0] {FA_KEEP, FA_CLR, FA_SET, FA_RES, FA_RESTORE} ctd_fact_e;
  typedef struct packed {
    logic [1:0] rp;
    logic spare;
    logic [2:0] r;
    ctd_loc_e src;
    ctd_loc_e dst;
    ctd_cls_e cls;
  } ctd_insn_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ctd_bus_s;

  // Length in the high nibble, CPU clocks in the low nibble
  function automatic logic [7:0] ctd_cost(input ctd_insn_s i);
    ctd_loc_e o;
    logic [7:0] c;
    o = (i.dst == LC_ACC) ? i.src : i.dst;
    c = {LEN2, CYC4};
    unique case (i.cls)
      CL_MOV:
        if (i.src == LC_IMM) c = {LEN3, CYC6};
        else if (o == LC_ABS) c = {LEN3, CYC8};
        else if (o == LC_DE || o == LC_HL) c = {LEN1, CYC6};
        else if (o == LC_HLB) c = {LEN2, CYC6};
      CL_XCH:
        if (i.src == LC_REG) c = (i.r == R_X) ? {LEN1, CYC4} : {LEN2, CYC6};
        else if (i.src == LC_DE || i.src == LC_HL) c = {LEN1, CYC8};
        else if (i.src == LC_HLB) c = {LEN2, CYC8};
        else c = {LEN2, CYC6};
      CL_MOVW:
        if (i.src == LC_IMM) c = {LEN3, CYC6};
        else if (i.src == LC_SAD) c = {LEN2, CYC6};
        else if (i.dst == LC_SAD) c = {LEN2, CYC8};
        else c = {LEN1, CYC4};
      CL_XCHW: c = {LEN1, CYC8};
      CL_ADD, CL_ADD_WITH_CARRY_OP, CL_SUB:
        if (i.dst == LC_SAD) c = {LEN3, CYC6};
        else if (i.src == LC_ABS) c = {LEN3, CYC8};
        else if (i.src == LC_HL) c = {LEN1, CYC6};
        else if (i.src == LC_HLB) c = {LEN2, CYC6};
      CL_BREL: c = {BR_LEN, BR_CYC};
      CL_BTBL: c = {TBL_LEN, TBL_CYC};
      CL_FLAG: c = {FLG_LEN, FLG_CYC};
      default: c = {LEN2, CYC4};
    endcase
    return c;
  endfunction
endpackage

/* core/ctd_core.sv */
// ctd_core: executes one transfer, exchange or add/subtract instruction at a time.
// Assumes a master that writes the operand word, then the instruction word.
//
// Contract
// - Byte register codes are X0 A1 C2 B3 E4 D5 L6 H7.
// - Register pair codes are AX0 BC1 DE2 HL3.
// - Short direct operands lie in FE20H..FF1FH; word ones are even.
// - Full addresses span the whole 64K; word transfers need even addresses.
// - Vector table operands are even and inside 0040H..007FH.
// - Immediates are 16 bits for words, 8 for bytes, 3 for bits.
// - Each flag is kept, cleared, set, taken from result or restored; the code does this for Z, AC and CY only.
// - Clock counts are in CPU clocks picked by the clock select register.
// - Immediate, absolute, relative and indirect addressing are distinct modes.
// - Relative jump offset is a signed 8-bit displacement added to PC.
// - A is the byte accumulator; the X and A pair is the word accumulator.
// - Each register pair is reachable as two separate byte halves.
// - Add immediate to short direct: 3 bytes, 6 clocks, writes memory, flags.
// - Add byte at HL plus offset to A: 2 bytes, 6 clocks, flags.
// - Add-with-carry immediate to short direct adds carry: 3 bytes, 6 clocks.
// - Add-with-carry absolute to A adds carry: 3 bytes, 8 clocks, flags.
// - Subtract immediate from short direct: 3 bytes, 6 clocks, stores, flags.
// - Subtract byte at HL plus offset from A: 2 bytes, 6 clocks, flags.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module ctd_core
#(
  parameter int MEM_AW = 16
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire ctd_pkg::ctd_bus_s bus_req,
  output logic [ctd_pkg::DATA_W-1:0] rd_data,
  output logic busy,
  output logic done
);
  import ctd_pkg::*;

  // Narrower memories alias; below 9 bits the short direct window folds onto itself
  if (MEM_AW < 9 || MEM_AW > 16)
  begin : g_bad_aw
    $error("MEM_AW must lie in 9..16");
  end

  logic [7:0] mem [2**MEM_AW];
  logic [7:0] gpr_reg [8];
  logic [7:0] gpr_next [8];
  ctd_insn_s insn_reg;
  ctd_insn_s insn_new;
  logic [31:0] oper_reg;
  logic [7:0] psw_reg, psw_next, saved_reg, cost_reg, cost_new;
  logic [15:0] pc_reg, pc_next, maddr_reg, ea, wv, ax, rpv;
  logic busy_reg, err_reg, done_reg, tick, issue, commit, bad, cin, hc, bus_ok;
  logic mem_we, mem_we2;
  logic [2:0] clksel_reg;
  logic [3:0] div_reg, cnt_reg, div_top;
  logic [31:0] rdata_reg, stat_word;
  logic [7:0] mlo, mhi, sv, av, wd_lo, wd_hi, fres;
  logic [8:0] sum;
  ctd_loc_e mloc;
  ctd_fact_e fz, fa, fc;

  function automatic logic [MEM_AW-1:0] mi(input logic [15:0] a);
    return a[MEM_AW-1:0];
  endfunction

  function automatic logic is_mem(input ctd_loc_e l);
    return l inside {LC_SAD, LC_SFR, LC_ABS, LC_DE, LC_HL, LC_HLB};
  endfunction

  function automatic logic flag_apply(input ctd_fact_e act, input logic cur, res, sav);
    logic f;
    f = cur;
    unique case (act)
      FA_KEEP: f = cur;
      FA_CLR: f = 1'b0;
      FA_SET: f = 1'b1;
      FA_RES: f = res;
      FA_RESTORE: f = sav;
      default: f = cur;
    endcase
    return f;
  endfunction

  assign rd_data = rdata_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign insn_new = ctd_insn_s'(bus_req.wdata[INSN_W-1:0]);
  assign cost_new = ctd_cost(insn_new);
  // Register writes are refused while an instruction is in flight
  assign bus_ok = clk_en & bus_req.wr & ~busy_reg;
  assign issue = bus_ok & (bus_req.addr == OFS_INSN);

  //////////////////////////////////////////////////////////////////////////
  // CPU clock: divide sys_clk by 2**select, clamped at the slowest setting
  assign div_top = 4'((5'h01 << clksel_reg) - 5'h01);
  assign tick = (div_reg >= div_top);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      div_reg <= 4'h0;
    else if (clk_en)
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencing: count the instruction's CPU clocks, commit on the last one
  assign commit = clk_en & busy_reg & tick & (cnt_reg == 4'h0) & ~bad;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      insn_reg <= '0;
      cost_reg <= 8'h00;
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      err_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      done_reg <= 1'b0;
      if (issue)
      begin
        insn_reg <= insn_new;
        cost_reg <= cost_new;
        cnt_reg <= cost_new[3:0] - 4'h1;
        busy_reg <= 1'b1;
        err_reg <= 1'b0;
      end
      else if (busy_reg && tick)
      begin
        if (cnt_reg == 4'h0)
        begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
          err_reg <= bad;
        end
        else
          cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Operand fetch and effective address for the addressing mode in use
  always_comb
  begin
    mloc = is_mem(insn_reg.dst) ? insn_reg.dst : insn_reg.src;
    if (insn_reg.cls inside {CL_BREL, CL_BTBL, CL_FLAG})
      mloc = LC_ABS;
    ax = {gpr_reg[R_A], gpr_reg[R_X]};
    rpv = {gpr_reg[{insn_reg.rp, 1'b1}], gpr_reg[{insn_reg.rp, 1'b0}]};
    unique case (mloc)
      LC_SFR: ea = {SFR_PAGE, oper_reg[23:16]};
      LC_DE: ea = {gpr_reg[R_D], gpr_reg[R_E]};
      LC_HL: ea = {gpr_reg[R_H], gpr_reg[R_L]};
      LC_HLB: ea = {gpr_reg[R_H], gpr_reg[R_L]} + {8'h00, oper_reg[7:0]};
      default: ea = oper_reg[31:16];
    endcase
    mlo = mem[mi(ea)];
    mhi = mem[mi(ea + 16'h0001)];
    bad = 1'b0;
    if (mloc == LC_SAD && (ea < SADDR_LO || ea > SADDR_HI))
      bad = 1'b1;
    if (insn_reg.cls == CL_MOVW && is_mem(mloc) && ea[0])
      bad = 1'b1;
    if (insn_reg.cls == CL_BTBL && (ea < VECT_LO || ea > VECT_HI || ea[0]))
      bad = 1'b1;
    unique case (insn_reg.src)
      LC_REG: sv = gpr_reg[insn_reg.r];
      LC_ACC: sv = gpr_reg[R_A];
      LC_IMM: sv = oper_reg[7:0];
      LC_PSW: sv = psw_reg;
      default: sv = mlo;
    endcase
    unique case (insn_reg.src)
      LC_IMM: wv = oper_reg[15:0];
      LC_RP: wv = rpv;
      LC_ACC: wv = ax;
      default: wv = {mhi, mlo};
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Arithmetic: carry in only for add-with-carry, borrow reported in carry
  assign av = (insn_reg.dst == LC_SAD) ? mlo : gpr_reg[R_A];
  assign cin = (insn_reg.cls == CL_ADD_WITH_CARRY_OP) & psw_reg[PSW_CY];
  assign sum = (insn_reg.cls == CL_SUB) ? ({1'b0, av} - {1'b0, sv})
    : ({1'b0, av} + {1'b0, sv} + {8'h00, cin});
  assign hc = (insn_reg.cls == CL_SUB) ? (av[3:0] < sv[3:0])
    : ((({1'b0, av[3:0]} + {1'b0, sv[3:0]}) + {4'h0, cin}) > 5'h0f);

  //////////////////////////////////////////////////////////////////////////
  // Next architectural state; applied only at commit so effects land together
  always_comb
  begin
    gpr_next = gpr_reg;
    psw_next = psw_reg;
    pc_next = pc_reg + {12'h000, cost_reg[7:4]};
    mem_we = 1'b0;
    mem_we2 = 1'b0;
    wd_lo = sv;
    wd_hi = 8'h00;
    fz = FA_KEEP;
    fa = FA_KEEP;
    fc = FA_KEEP;
    fres = 8'h00;
    unique case (insn_reg.cls)
      CL_MOV:
        unique case (insn_reg.dst)
          LC_REG: gpr_next[insn_reg.r] = sv;
          LC_ACC: gpr_next[R_A] = sv;
          LC_PSW:
          begin
            psw_next = sv;
            fres = sv;
            fz = FA_RES;
            fa = FA_RES;
            fc = FA_RES;
          end
          default: mem_we = 1'b1;
        endcase
      CL_XCH:
      begin
        gpr_next[R_A] = sv;
        wd_lo = gpr_reg[R_A];
        if (insn_reg.src == LC_REG)
          gpr_next[insn_reg.r] = gpr_reg[R_A];
        else
          mem_we = 1'b1;
      end
      CL_MOVW:
        unique case (insn_reg.dst)
          LC_RP:
          begin
            gpr_next[{insn_reg.rp, 1'b1}] = wv[15:8];
            gpr_next[{insn_reg.rp, 1'b0}] = wv[7:0];
          end
          LC_ACC:
          begin
            gpr_next[R_A] = wv[15:8];
            gpr_next[R_X] = wv[7:0];
          end
          default:
          begin
            mem_we = 1'b1;
            mem_we2 = 1'b1;
            wd_lo = wv[7:0];
            wd_hi = wv[15:8];
          end
        endcase
      CL_XCHW:
      begin
        gpr_next[{insn_reg.rp, 1'b1}] = ax[15:8];
        gpr_next[{insn_reg.rp, 1'b0}] = ax[7:0];
        gpr_next[R_A] = rpv[15:8];
        gpr_next[R_X] = rpv[7:0];
      end
      CL_ADD, CL_ADD_WITH_CARRY_OP, CL_SUB:
      begin
        if (insn_reg.dst == LC_SAD)
        begin
          mem_we = 1'b1;
          wd_lo = sum[7:0];
        end
        else
          gpr_next[R_A] = sum[7:0];
        fres[PSW_Z] = (sum[7:0] == 8'h00);
        fres[PSW_AC] = hc;
        fres[PSW_CY] = sum[8];
        fz = FA_RES;
        fa = FA_RES;
        fc = FA_RES;
      end
      CL_BREL: pc_next = pc_next + {{8{oper_reg[7]}}, oper_reg[7:0]};
      CL_BTBL: pc_next = {mhi, mlo};
      CL_FLAG:
      begin
        fz = ctd_fact_e'(oper_reg[2:0]);
        fa = ctd_fact_e'(oper_reg[6:4]);
        fc = ctd_fact_e'(oper_reg[10:8]);
      end
      default: pc_next = pc_reg;
    endcase
    psw_next[PSW_Z] = flag_apply(fz, psw_reg[PSW_Z], fres[PSW_Z], saved_reg[PSW_Z]);
    psw_next[PSW_AC] = flag_apply(fa, psw_reg[PSW_AC], fres[PSW_AC], saved_reg[PSW_AC]);
    psw_next[PSW_CY] = flag_apply(fc, psw_reg[PSW_CY], fres[PSW_CY], saved_reg[PSW_CY]);
  end

  //////////////////////////////////////////////////////////////////////////
  // Byte registers: commit wins; the port loads them only while idle
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 8; i++)
        gpr_reg[i] <= 8'h00;
    end
    else if (commit)
      gpr_reg <= gpr_next;
    else if (bus_ok && (bus_req.addr == OFS_REGLO || bus_req.addr == OFS_REGHI))
    begin
      for (int i = 0; i < 4; i++)
        gpr_reg[{bus_req.addr == OFS_REGHI, 2'(i)}] <= bus_req.wdata[8*i +: 8];
    end
  end

  // Status word, counter, clock select and port-side registers
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      psw_reg <= PSW_RST;
      saved_reg <= PSW_RST;
      pc_reg <= 16'h0000;
      clksel_reg <= 3'h0;
      maddr_reg <= 16'h0000;
      oper_reg <= 32'h0000_0000;
    end
    else if (commit)
    begin
      psw_reg <= psw_next;
      pc_reg <= pc_next;
    end
    else if (bus_ok)
    begin
      unique case (bus_req.addr)
        OFS_OPER: oper_reg <= bus_req.wdata;
        OFS_PSW: psw_reg <= bus_req.wdata[7:0];
        OFS_SAVED: saved_reg <= bus_req.wdata[7:0];
        OFS_PC: pc_reg <= bus_req.wdata[15:0];
        OFS_MADDR: maddr_reg <= bus_req.wdata[15:0];
        OFS_CLKSEL: clksel_reg <= (bus_req.wdata[2:0] > CLKSEL_MAX) ? CLKSEL_MAX
          : bus_req.wdata[2:0];
        default: ;
      endcase
    end
  end

  // Data memory; no reset, contents are undefined until written
  always_ff @(posedge sys_clk)
  begin
    if (commit && mem_we)
    begin
      mem[mi(ea)] <= wd_lo;
      if (mem_we2)
        mem[mi(ea + 16'h0001)] <= wd_hi;
    end
    else if (bus_ok && bus_req.addr == OFS_MDATA)
      mem[mi(maddr_reg)] <= bus_req.wdata[7:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // Read port: data stands one cycle after the strobe, zero otherwise
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[STAT_BUSY] = busy_reg;
    stat_word[STAT_ERR] = err_reg;
    stat_word[STAT_LEN_LSB +: 4] = cost_reg[7:4];
    stat_word[STAT_CYC_LSB +: 4] = cost_reg[3:0];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_reg <= 32'h0000_0000;
    else if (clk_en)
    begin
      rdata_reg <= 32'h0000_0000;
      if (bus_req.rd)
        unique case (bus_req.addr)
          OFS_INSN: rdata_reg <= {14'h0000, insn_reg};
          OFS_OPER: rdata_reg <= oper_reg;
          OFS_STAT: rdata_reg <= stat_word;
          OFS_PSW: rdata_reg <= {24'h000000, psw_reg};
          OFS_SAVED: rdata_reg <= {24'h000000, saved_reg};
          OFS_CLKSEL: rdata_reg <= {29'h0, clksel_reg};
          OFS_PC: rdata_reg <= {16'h0000, pc_reg};
          OFS_REGLO: rdata_reg <= {gpr_reg[R_B], gpr_reg[R_C], gpr_reg[R_A], gpr_reg[R_X]};
          OFS_REGHI: rdata_reg <= {gpr_reg[R_H], gpr_reg[R_L], gpr_reg[R_D], gpr_reg[R_E]};
          OFS_MADDR: rdata_reg <= {16'h0000, maddr_reg};
          OFS_MDATA: rdata_reg <= {24'h000000, mem[mi(maddr_reg)]};
          default: rdata_reg <= 32'h0000_0000;
        endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks; helper counts CPU clocks spent by the current instruction
  logic [3:0] ticks_reg;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ticks_reg <= 4'h0;
    else if (issue)
      ticks_reg <= 4'h0;
    else if (clk_en && busy_reg && tick)
      ticks_reg <= ticks_reg + 4'h1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_cpu_clk_count: assert property (done_reg |-> ticks_reg == cost_reg[3:0])
    else $error("instruction did not take its CPU clock count");
  a_move_flags_kept: assert property (commit && insn_reg.cls inside {CL_MOV, CL_XCH}
    && insn_reg.dst != LC_PSW |=> psw_reg == $past(psw_reg))
    else $error("move or exchange changed the flags");
  a_saddr_window: assert property (commit && mloc == LC_SAD |->
    ea >= 16'hfe20 && ea <= 16'hff1f)
    else $error("short direct access outside its window");
  a_word_even: assert property (commit && insn_reg.cls == CL_MOVW && is_mem(mloc)
    |-> ea[0] == 1'b0)
    else $error("word transfer on odd address");
  a_vect_even: assert property (commit && insn_reg.cls == CL_BTBL |->
    ea >= 16'h0040 && ea <= 16'h007e && !ea[0])
    else $error("vector operand outside table");
  a_rel_jump: assert property (commit && insn_reg.cls == CL_BREL |=> pc_reg ==
    $past(pc_reg) + 16'h0002 + {{8{$past(oper_reg[7])}}, $past(oper_reg[7:0])})
    else $error("relative jump target wrong");
  a_add_saddr_cost: assert property (issue && insn_new.cls == CL_ADD
    && insn_new.dst == LC_SAD |=> cost_reg == 8'h36 ##1 busy_reg[*5])
    else $error("add to short direct cost wrong");
  a_add_with_carry_op_abs_cost: assert property (issue && insn_new.cls == CL_ADD_WITH_CARRY_OP
    && insn_new.dst == LC_ACC && insn_new.src == LC_ABS |=> cost_reg == 8'h38)
    else $error("add-with-carry absolute cost wrong");
  a_hlb_zero_flag: assert property (commit && insn_reg.cls inside {CL_ADD, CL_SUB}
    && insn_reg.dst == LC_ACC |=> psw_reg[PSW_Z] == (gpr_reg[R_A] == 8'h00))
    else $error("zero flag does not match accumulator");
  a_sub_borrow: assert property (commit && insn_reg.cls == CL_SUB && insn_reg.dst == LC_SAD
    |=> psw_reg[PSW_CY] == ($past(mlo) < $past(sv)))
    else $error("borrow flag wrong after subtract");
  a_xch_swap: assert property (commit && insn_reg.cls == CL_XCH && insn_reg.src == LC_REG
    |=> gpr_reg[R_A] == $past(sv) && gpr_reg[$past(insn_reg.r)] == $past(gpr_reg[R_A]))
    else $error("exchange did not swap");

  c_add_done: cover property (commit && insn_reg.cls == CL_ADD_WITH_CARRY_OP);
  c_xchw_done: cover property (commit && insn_reg.cls == CL_XCHW);
  c_bad_operand: cover property (done_reg && err_reg);
  c_slow_clock: cover property (done_reg && clksel_reg == CLKSEL_MAX);
endmodule // ctd_core

/* verification/tb_cpu_transfer_arith_decode.sv */
// tb_cpu_transfer_arith_decode: random and corner tests of the ctd core.
// Assumes reads answer one cycle late and done pulses once per instruction.
`timescale 1ns/10ps
module tb_cpu_transfer_arith_decode;
  import ctd_pkg::*;
  logic sys_clk, reset_n, clk_en, busy, done;
  ctd_bus_s bus_req;
  logic [DATA_W-1:0] rd_data, d, rnd;
  logic [7:0] rg [8];
  logic [7:0] program_status_word, b, m, f;
  logic [15:0] a, hl;
  integer seed, fails, tests_run, i, n, sel;
  ctd_cls_e ops [3];
  ////////////////////////////////////////////////////////////////
  ctd_core #(.MEM_AW(12)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .bus_req(bus_req), .rd_data(rd_data), .busy(busy), .done(done));
  // Free running 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic end_sim();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // Plain port master: one-cycle strobes, data sampled in the cycle after
  task automatic bw(input logic [7:0] ad, input logic [31:0] v);
    @(posedge sys_clk);
    bus_req <= '{addr: ad, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic br(input logic [7:0] ad);
    @(posedge sys_clk);
    bus_req.addr <= ad;
    bus_req.rd <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask
  // Issue one instruction, count busy cycles, check cost and error status
  task automatic ex(input ctd_cls_e c, input ctd_loc_e ds, input ctd_loc_e sr,
      input logic [2:0] r, input logic [1:0] rp, input logic [31:0] op,
      input logic [3:0] len, input logic [3:0] cyc, input logic err);
    ctd_insn_s ins;
    integer k;
    ins = '{rp: rp, spare: 1'b0, r: r, src: sr, dst: ds, cls: c};
    bw(OFS_OPER, op);
    bw(OFS_INSN, {14'h0, ins});
    n = 0;
    #1;
    for (k = 0; k < 300 && done !== 1'b1; k++)
    begin
      if (busy === 1'b1) n++;
      @(posedge sys_clk);
      #1;
    end
    chk({31'h0, done}, 32'h1, "done");
    // Divider may tick early once, so allow one short divided clock
    chk({31'h0, n > (cyc - 1) * (1 << sel) && n <= cyc * (1 << sel)}, 32'h1, "clocks");
    br(OFS_STAT);
    chk({d[19:16], d[11:8], d[1:0]}, {cyc, len, err, 1'b0}, "stat");
  endtask
  task automatic chkregs(input string s);
    br(OFS_REGLO);
    chk(d, {rg[3], rg[2], rg[1], rg[0]}, "reglo");
    br(OFS_REGHI);
    chk(d, {rg[7], rg[6], rg[5], rg[4]}, "reghi");
    br(OFS_PSW);
    chk(d, {24'h0, program_status_word}, "psw");
    $display("test %s finished", s);
  endtask
  // Expected byte result and Z/AC/CY flags
  function automatic logic [15:0] alu(input logic [7:0] x, input logic [7:0] y,
      input logic sb, input logic ci);
    logic [8:0] s;
    logic h;
    s = sb ? ({1'b0, x} - {1'b0, y} - {8'h0, ci}) : ({1'b0, x} + {1'b0, y} + {8'h0, ci});
    h = sb ? ({1'b0, x[3:0]} < {1'b0, y[3:0]} + {4'h0, ci})
      : ({1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci} > 5'h0f);
    return {s[7:0], 1'b0, s[7:0] == 8'h00, 1'b0, h, 3'b000, s[8]};
  endfunction
  task automatic upd(input ctd_cls_e c, input logic [7:0] x, input logic [7:0] y);
    {m, f} = alu(x, y, c == CL_SUB, c == CL_ADD_WITH_CARRY_OP && program_status_word[0]);
    program_status_word = (program_status_word & 8'hae) | f;
  endtask
  ////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected run of under two thousand cycles
  initial
  begin
    #500000;
    fails++;
    end_sim();
  end
  initial
  begin
    seed = 32'h4d3b;
    fails = 0;
    tests_run = 0;
    sel = 0;
    ops = '{CL_ADD, CL_ADD_WITH_CARRY_OP, CL_SUB};
    clk_en = 1'b1;
    reset_n = 1'b0;
    bus_req = '0;
    program_status_word = PSW_RST;
    rg = '{default: 8'h00};
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    chkregs("reset");
    // Pairs then single registers, by code
    for (i = 0; i < 4; i++)
    begin
      rnd = $random(seed);
      ex(CL_MOVW, LC_RP, LC_IMM, 3'h0, 2'(i), {16'h0, rnd[15:0]}, LEN3, CYC6, 1'b0);
      {rg[2*i+1], rg[2*i]} = rnd[15:0];
    end
    chkregs("pairs");
    for (i = 0; i < 8; i++)
    begin
      rnd = $random(seed);
      ex(CL_MOV, LC_REG, LC_IMM, 3'(i), 2'h0, {24'h0, rnd[7:0]}, LEN3, CYC6, 1'b0);
      rg[i] = rnd[7:0];
    end
    chkregs("bytes");
    // Accumulator arithmetic with corner operands first
    for (i = 0; i < 12; i++)
    begin
      rnd = $random(seed);
      b = (i < 3) ? 8'h01 : rnd[15:8];
      rg[1] = (i < 3) ? ((i == 2) ? 8'h00 : 8'hff) : rnd[7:0];
      ex(CL_MOV, LC_REG, LC_IMM, R_A, 2'h0, {24'h0, rg[1]}, LEN3, CYC6, 1'b0);
      ex(ops[i%3], LC_ACC, LC_IMM, 3'h0, 2'h0, {24'h0, b}, LEN2, CYC4, 1'b0);
      upd(ops[i%3], rg[1], b);
      rg[1] = m;
    end
    chkregs("acc");
    // Short direct read-modify-write
    for (i = 0; i < 6; i++)
    begin
      rnd = $random(seed);
      a = (i == 0) ? SADDR_HI : SADDR_LO + {8'h0, rnd[23:16]};
      ex(CL_MOV, LC_SAD, LC_IMM, 3'h0, 2'h0, {a, 8'h0, rnd[7:0]}, LEN3, CYC6, 1'b0);
      ex(ops[i%3], LC_SAD, LC_IMM, 3'h0, 2'h0, {a, 8'h0, rnd[15:8]}, LEN3, CYC6, 1'b0);
      upd(ops[i%3], rnd[7:0], rnd[15:8]);
      bw(OFS_MADDR, {16'h0, a});
      br(OFS_MDATA);
      chk(d[7:0], m, "saddr");
    end
    chkregs("saddr");
    // Indexed and absolute memory operands
    hl = {rg[7], rg[6]};
    for (i = 0; i < 3; i++)
    begin
      rnd = $random(seed);
      ex(CL_MOV, LC_HLB, LC_ACC, 3'h0, 2'h0, {24'h0, rnd[7:0]}, LEN2, CYC6, 1'b0);
      b = rg[1];
      a = hl + {8'h0, rnd[7:0]};
      rg[1] = rnd[15:8];
      ex(CL_MOV, LC_REG, LC_IMM, R_A, 2'h0, {24'h0, rg[1]}, LEN3, CYC6, 1'b0);
      if (i == 2)
        ex(CL_ADD_WITH_CARRY_OP, LC_ACC, LC_ABS, 3'h0, 2'h0, {a, 16'h0}, LEN3, CYC8, 1'b0);
      else
        ex(ops[i*2], LC_ACC, LC_HLB, 3'h0, 2'h0, {24'h0, rnd[7:0]}, LEN2, CYC6, 1'b0);
      upd((i == 2) ? CL_ADD_WITH_CARRY_OP : ops[i*2], rg[1], b);
      rg[1] = m;
    end
    chkregs("memory");
    // Status word load, then exchange keeps flags
    ex(CL_MOV, LC_PSW, LC_IMM, 3'h0, 2'h0, 32'h51, LEN3, CYC6, 1'b0);
    program_status_word = 8'h51;
    ex(CL_XCH, LC_ACC, LC_REG, R_X, 2'h0, 32'h0, LEN1, CYC4, 1'b0);
    {rg[0], rg[1]} = {rg[1], rg[0]};
    chkregs("xch");
    // Word exchange with DE, then flag actions: Z restored, AC set, CY cleared
    ex(CL_XCHW, LC_ACC, LC_RP, 3'h0, RP_DE, 32'h0, LEN1, CYC8, 1'b0);
    {rg[1], rg[0], rg[5], rg[4]} = {rg[5], rg[4], rg[1], rg[0]};
    bw(OFS_SAVED, 32'h41);
    ex(CL_FLAG, LC_REG, LC_IMM, 3'h0, 2'h0, 32'h0124, FLG_LEN, FLG_CYC, 1'b0);
    program_status_word = (program_status_word & 8'hae) | 8'h50;
    chkregs("flags");
    // Out-of-window and odd word operands are refused
    ex(CL_MOV, LC_SAD, LC_IMM, 3'h0, 2'h0, {16'hfe1f, 16'h005a}, LEN3, CYC6, 1'b1);
    ex(CL_MOVW, LC_RP, LC_SAD, 3'h0, 2'h0, {16'hfe21, 16'h0}, LEN2, CYC6, 1'b1);
    chkregs("refuse");
    // Backward relative branch
    br(OFS_PC);
    a = d[15:0] + {12'h0, BR_LEN} + 16'hfff0;
    ex(CL_BREL, LC_REG, LC_IMM, 3'h0, 2'h0, 32'hf0, BR_LEN, BR_CYC, 1'b0);
    br(OFS_PC);
    chk(d[15:0], a, "pc");
    // Divided CPU clock stretches the instruction
    bw(OFS_CLKSEL, 32'h7);
    br(OFS_CLKSEL);
    chk(d, {29'h0, CLKSEL_MAX}, "clksel");
    bw(OFS_CLKSEL, 32'h2);
    sel = 2;
    ex(CL_MOV, LC_REG, LC_IMM, R_B, 2'h0, 32'h3c, LEN3, CYC6, 1'b0);
    rg[3] = 8'h3c;
    chkregs("divided");
    end_sim();
  end
endmodule // tb_cpu_transfer_arith_decode
